//--- core/sarpr_core.sv
// conversion control and parallel readout of the 18-bit converter
//
// Summary of operation
// - internal timing, conversion lasts 1.52 us
// - trigger fall switches sample to hold
// - busy high from trigger fall until done
// - sampling restarts on busy fall while select is low, or on select fall outside conversion
// - bus driven only when select and read low
// - straight binary 18-bit result code
// - both selects low gives full word
// - width high gives bits 1:0 on 3:2
// - upper lane gives bits 9:2 on 17:10
// - both high gives bits 1:0 on 11:10
// - toggling or held read strobe both work
// - first three conversions flagged invalid
`timescale 1ns/1ps
`include "sarpr_regs.svh"
module sarpr_core (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sample_hold_trigger_n,
  input  wire logic        chip_select_n,
  input  wire logic        read_strobe_n,
  input  wire logic        upper_lane_select,
  input  wire logic        width_select,
  input  wire logic [17:0] sample_in,
  input  wire logic        sample_valid,
  output logic             sample_ready,
  output logic             busy,
  output logic             sampling,
  output logic             result_valid,
  output logic [17:0]      output_bus_o,
  output logic [17:0]      output_bus_oe
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] trig_s_q;
  logic [2:0] cs_s_q;
  logic [2:0] rd_s_q;
  logic [2:0] up_s_q;
  logic [2:0] wd_s_q;
  logic       trig_q;
  logic       cs_q;
  logic       rd_q;
  logic       up_q;
  logic       wd_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_s_q <= 3'h7;
      cs_s_q   <= 3'h7;
      rd_s_q   <= 3'h7;
      up_s_q   <= 3'h0;
      wd_s_q   <= 3'h0;
    end else begin
      trig_s_q <= {trig_s_q[1:0], sample_hold_trigger_n};
      cs_s_q   <= {cs_s_q[1:0], chip_select_n};
      rd_s_q   <= {rd_s_q[1:0], read_strobe_n};
      up_s_q   <= {up_s_q[1:0], upper_lane_select};
      wd_s_q   <= {wd_s_q[1:0], width_select};
    end
  end
  wire trig_ag = trig_s_q[2] == trig_s_q[1];
  wire cs_ag   = cs_s_q[2] == cs_s_q[1];
  wire rd_ag   = rd_s_q[2] == rd_s_q[1];
  wire up_ag   = up_s_q[2] == up_s_q[1];
  wire wd_ag   = wd_s_q[2] == wd_s_q[1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_q <= 1'b1;
      cs_q   <= 1'b1;
      rd_q   <= 1'b1;
      up_q   <= 1'b0;
      wd_q   <= 1'b0;
    end else begin
      trig_q <= trig_ag ? trig_s_q[2] : trig_q;
      cs_q   <= cs_ag ? cs_s_q[2] : cs_q;
      rd_q   <= rd_ag ? rd_s_q[2] : rd_q;
      up_q   <= up_ag ? up_s_q[2] : up_q;
      wd_q   <= wd_ag ? wd_s_q[2] : wd_q;
    end
  end
  // trigger only counts while select is low
  wire trig_fall = trig_ag && !trig_s_q[2] && trig_q && !cs_q;
  wire cs_fall   = cs_ag && !cs_s_q[2] && cs_q;
  // ------------------------------------------------------------
  // conversion state machine
  // ------------------------------------------------------------
  localparam int CONV_CYC = `SARPR_CONV_CYC;
  sarpr_pkg::sarpr_state_e st_q;
  sarpr_pkg::sarpr_state_e st_d;
  logic [5:0]         cnt_q;
  logic [1:0]         trim_q;
  logic               valid_q;
  sarpr_pkg::sarpr_word_t res_q;
  sarpr_pkg::sarpr_word_t hold_q;
  logic               samp_q;
  wire  [17:0]        fifo_data;
  wire                fifo_valid;
  wire conv_end = (st_q == sarpr_pkg::SARPR_CONV) &&
                  (cnt_q == 6'(CONV_CYC - 1));
  always_comb begin
    st_d = st_q;
    case (st_q)
      sarpr_pkg::SARPR_SAMPLE: begin
        if (trig_fall) begin
          st_d = sarpr_pkg::SARPR_CONV;
        end
      end
      sarpr_pkg::SARPR_CONV: begin
        if (conv_end) begin
          st_d = sarpr_pkg::SARPR_DONE;
        end
      end
      sarpr_pkg::SARPR_DONE: begin
        if (trig_fall) begin
          st_d = sarpr_pkg::SARPR_CONV;
        end
      end
      default: st_d = sarpr_pkg::SARPR_SAMPLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= sarpr_pkg::SARPR_SAMPLE;
      cnt_q <= 6'h00;
    end else begin
      st_q  <= st_d;
      cnt_q <= (st_q == sarpr_pkg::SARPR_CONV) ? cnt_q + 6'h01 : 6'h00;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= `SARPR_CODE_ZERO;
    end else if (trig_fall && st_q != sarpr_pkg::SARPR_CONV) begin
      hold_q <= fifo_valid ? fifo_data : hold_q;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_q   <= `SARPR_CODE_ZERO;
      trim_q  <= 2'h0;
      valid_q <= 1'b0;
    end else if (conv_end) begin
      res_q   <= hold_q;
      trim_q  <= (trim_q == `SARPR_TRIM_CONVS) ? trim_q : trim_q + 2'h1;
      valid_q <= (trim_q == `SARPR_TRIM_CONVS) | valid_q;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_q <= 1'b1;
    end else if (trig_fall) begin
      samp_q <= 1'b0;
    end else if ((conv_end && !cs_q) ||
                 (cs_fall && st_q != sarpr_pkg::SARPR_CONV)) begin
      samp_q <= 1'b1;
    end
  end
  assign busy         = st_q == sarpr_pkg::SARPR_CONV;
  assign sampling     = samp_q;
  assign result_valid = valid_q;
  // ------------------------------------------------------------
  // sample source fifo
  // ------------------------------------------------------------
  wire fifo_pop = trig_fall && st_q != sarpr_pkg::SARPR_CONV;
  sarpr_fifo #(
    .WIDTH (`SARPR_RES_W),
    .DEPTH (`SARPR_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (sample_in),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );
  // ------------------------------------------------------------
  // output lane selection
  // ------------------------------------------------------------
  wire [1:0]  lane = {up_q, wd_q};
  wire [17:0] w_full = res_q;
  wire [17:0] w_lo16 = {14'h3fff, res_q[1:0], 2'h3};
  wire [17:0] w_mid8 = {res_q[9:2], 10'h3ff};
  wire [17:0] w_lo8  = {6'h3f, res_q[1:0], 10'h3ff};
  logic [17:0] bus_d;
  always_comb begin
    case (lane)
      2'b00:   bus_d = w_full;
      2'b01:   bus_d = w_lo16;
      2'b10:   bus_d = w_mid8;
      2'b11:   bus_d = w_lo8;
      default: bus_d = w_full;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_bus_o <= 18'h00000;
    end else begin
      output_bus_o <= bus_d;
    end
  end
  // drive only on select and read
  wire drive = !cs_q && !rd_q;
  assign output_bus_oe = {18{drive}};
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_trig;
    trig_fall && !busy;
  endsequence
  sequence s_conv_run;
    busy [*8] ##1 busy [*8] ##1 busy [*8] ##1 busy [*8] ##1 busy [*6];
  endsequence
  a_busy_rise_trig: assert property (@(posedge clk) disable iff (!rst_n)
    s_trig |=> busy)
    else $error("busy not raised after trigger");
  a_busy_conv_len: assert property (@(posedge clk) disable iff (!rst_n)
    s_trig |=> s_conv_run ##1 !busy)
    else $error("conversion length wrong");
  a_hold_on_trig: assert property (@(posedge clk) disable iff (!rst_n)
    s_trig |=> !sampling)
    else $error("sampling after trigger");
  a_bus_enable: assert property (@(posedge clk) disable iff (!rst_n)
    output_bus_oe[0] == (!cs_q && !rd_q))
    else $error("bus enable mismatch");
  a_result_stable: assert property (@(posedge clk) disable iff (!rst_n)
    !conv_end |=> $stable(res_q))
    else $error("result changed without conversion");
  a_lane_full: assert property (@(posedge clk) disable iff (!rst_n)
    lane == 2'b00 |=> output_bus_o == $past(res_q))
    else $error("full word lane wrong");
  a_lane_lo16: assert property (@(posedge clk) disable iff (!rst_n)
    lane == 2'b01 |=> output_bus_o[3:2] == $past(res_q[1:0]) &&
    output_bus_o[17:4] == 14'h3fff)
    else $error("width lane wrong");
  a_lane_mid8: assert property (@(posedge clk) disable iff (!rst_n)
    lane == 2'b10 |=> output_bus_o[17:10] == $past(res_q[9:2]) &&
    output_bus_o[9:0] == 10'h3ff)
    else $error("upper lane wrong");
  a_lane_lo8: assert property (@(posedge clk) disable iff (!rst_n)
    lane == 2'b11 |=> output_bus_o[11:10] == $past(res_q[1:0]) &&
    output_bus_o[9:0] == 10'h3ff)
    else $error("low byte lane wrong");
  a_sample_restart: assert property (@(posedge clk) disable iff (!rst_n)
    conv_end && !cs_q && !trig_fall |=> sampling)
    else $error("sampling not restarted");
  a_trim_count: assert property (@(posedge clk) disable iff (!rst_n)
    result_valid |=> result_valid)
    else $error("valid flag dropped");
endmodule

//--- core/sarpr_regs.svh
// timing constants and code values for the converter readout
`ifndef SARPR_REGS_SVH
`define SARPR_REGS_SVH
`define SARPR_CLK_PS         40000
`define SARPR_CONV_TIME_PS   1520000
`define SARPR_CONV_CYC       (`SARPR_CONV_TIME_PS / `SARPR_CLK_PS)
`define SARPR_RES_W          18
`define SARPR_CODE_ZERO      18'h00000
`define SARPR_CODE_MID       18'h20000
`define SARPR_CODE_FULL      18'h3ffff
`define SARPR_TRIM_CONVS     2'h3
`define SARPR_FIFO_DEPTH     32
`endif

//--- core/sarpr_pkg.sv
// types for the converter readout block
package sarpr_pkg;
  typedef enum logic [1:0] {
    SARPR_SAMPLE = 2'b00,
    SARPR_CONV   = 2'b01,
    SARPR_DONE   = 2'b10
  } sarpr_state_e;
  typedef logic [17:0] sarpr_word_t;
endpackage

//--- core/sarpr_fifo.sv
// parameterised fifo with valid and ready on both sides
`timescale 1ns/1ps
module sarpr_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  wire              push;
  wire              pop;
  assign in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
  assign out_valid = wp_q != rp_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rp_q[AW-1:0]];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule

//--- dv/sarpr_host.sv
// host model that drives the converter control pins
`timescale 1ns/1ps
module sarpr_host (
  input  wire logic        clk,
  input  wire logic        busy,
  input  wire logic [17:0] bus,
  output logic             sample_hold_trigger_n,
  output logic             chip_select_n,
  output logic             read_strobe_n,
  output logic             upper_lane_select,
  output logic             width_select
);
  initial begin
    sample_hold_trigger_n = 1'b1;
    chip_select_n         = 1'b1;
    read_strobe_n         = 1'b1;
    upper_lane_select     = 1'b0;
    width_select          = 1'b0;
  end
  // trigger, then wait on busy fall
  task automatic convert(input logic sel_n, input logic drop,
                         output int hi);
    int n;
    n  = 0;
    hi = 0;
    @(posedge clk);
    chip_select_n <= sel_n;
    repeat (4) @(posedge clk);
    sample_hold_trigger_n <= 1'b0;
    while (busy !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    if (drop) begin
      @(posedge clk);
      chip_select_n <= 1'b1;
    end
    while (busy === 1'b1 && hi < 90) begin
      @(negedge clk);
      hi++;
    end
    @(posedge clk);
    sample_hold_trigger_n <= 1'b1;
  endtask
  // lane reads, strobe toggled or held
  task automatic read(input logic u, input logic w, input logic hold,
                      output logic [17:0] d);
    @(posedge clk);
    upper_lane_select <= u;
    width_select      <= w;
    chip_select_n     <= 1'b0;
    read_strobe_n     <= 1'b0;
    repeat (7) @(posedge clk);
    d = bus;
    if (!hold) begin
      read_strobe_n <= 1'b1;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic idle();
    @(posedge clk);
    read_strobe_n <= 1'b1;
    chip_select_n <= 1'b1;
  endtask
endmodule

//--- dv/sarpr_core_test.sv
// self-checking bench for the converter readout block
`timescale 1ns/1ps
`include "sarpr_regs.svh"
module sarpr_core_test;
  logic        clk;
  logic        rst_n;
  logic        sample_hold_trigger_n;
  logic        chip_select_n;
  logic        read_strobe_n;
  logic        upper_lane_select;
  logic        width_select;
  logic [17:0] sample_in;
  logic        sample_valid;
  logic        sample_ready;
  logic        busy;
  logic        sampling;
  logic        result_valid;
  logic [17:0] output_bus_o;
  logic [17:0] output_bus_oe;
  wire  [17:0] bus;
  int          miscompares;
  int          checks_done;
  integer      seed;
  int          hi;
  logic [17:0] q[$];
  logic [17:0] cur;
  logic [17:0] v;
  logic [17:0] d;
  for (genvar k = 0; k < 18; k++) begin : g_bus
    assign bus[k] = output_bus_oe[k] ? output_bus_o[k] : 1'bz;
  end
  sarpr_core sarpr_core_i (
    .clk, .rst_n, .sample_hold_trigger_n, .chip_select_n, .read_strobe_n,
    .upper_lane_select, .width_select, .sample_in, .sample_valid,
    .sample_ready, .busy, .sampling, .result_valid, .output_bus_o,
    .output_bus_oe
  );
  sarpr_host sarpr_host_i (
    .clk, .busy, .bus, .sample_hold_trigger_n, .chip_select_n,
    .read_strobe_n, .upper_lane_select, .width_select
  );
  // expected bus word for each lane selection
  function automatic logic [17:0] lane(logic [17:0] r, logic u, logic w);
    case ({u, w})
      2'b00:   return r;
      2'b01:   return {14'h3fff, r[1:0], 2'h3};
      2'b10:   return {r[9:2], 10'h3ff};
      default: return {6'h3f, r[1:0], 10'h3ff};
    endcase
  endfunction
  task automatic check(string nm, logic [17:0] seen, logic [17:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // watchdog, about 20000 cycles against some 3300 needed
  initial begin
    #800000;
    miscompares++;
    wrap_up();
  end
  initial begin
    rst_n        = 1'b0;
    sample_in    = 18'h0;
    sample_valid = 1'b0;
    seed         = 88461;
    miscompares  = 0;
    checks_done  = 0;
    cur          = 18'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    v = {14'h0, busy, sampling, result_valid, sample_ready};
    check("rst_flags", v, 18'h5);
    check("rst_oe", output_bus_oe, 18'h0);
    sarpr_host_i.convert(1'b1, 1'b0, hi);
    check("refused", 18'(hi), 18'h0);
    // fill the buffer past its depth
    for (int i = 0; i <= `SARPR_FIFO_DEPTH; i++) begin
      @(posedge clk);
      if (sample_valid && sample_ready) q.push_back(sample_in);
      case (i)
        0: v = `SARPR_CODE_ZERO;
        1: v = `SARPR_CODE_MID;
        2: v = `SARPR_CODE_FULL;
        default: v = 18'($random(seed));
      endcase
      sample_in    <= v;
      sample_valid <= 1'b1;
    end
    @(posedge clk);
    if (sample_valid && sample_ready) q.push_back(sample_in);
    sample_valid <= 1'b0;
    @(negedge clk);
    check("full", 18'(sample_ready), 18'h0);
    check("depth", 18'(q.size()), 18'(`SARPR_FIFO_DEPTH));
    // drain by conversions, last one with the buffer empty
    for (int k = 0; k <= `SARPR_FIFO_DEPTH; k++) begin
      if (q.size() > 0) cur = q.pop_front();
      sarpr_host_i.convert(1'b0, k == 5, hi);
      check("busy_len", 18'(hi), 18'(`SARPR_CONV_CYC));
      check("sampling", 18'(sampling), 18'(k != 5));
      check("valid", 18'(result_valid), 18'(k >= 3));
      for (int m = 0; m < 4; m++) begin
        sarpr_host_i.read(m[1], m[0], k[0], d);
        check("lane", d, lane(cur, m[1], m[0]));
      end
      repeat (5) @(posedge clk);
      check("samp_cs", 18'(sampling), 18'h1);
      check("oe_rd", output_bus_oe, k[0] ? 18'h3ffff : 18'h0);
      sarpr_host_i.idle();
      repeat (5) @(posedge clk);
      check("oe_idle", output_bus_oe, 18'h0);
    end
    wrap_up();
  end
endmodule
